// >>> shared/timer_pair_defs.svh
`ifndef TIMER_PAIR_DEFS_SVH
`define TIMER_PAIR_DEFS_SVH

// =====================================================================
// register addresses on the access port
`define ADDR_CMP1 4'h0
`define ADDR_CMP2 4'h1
`define ADDR_CNT1 4'h2
`define ADDR_CNT2 4'h3
`define ADDR_CLKSEL 4'h4
`define ADDR_MODE 4'h5
`define ADDR_OUTCTL 4'h6

// =====================================================================
// timer_mode_control fields
`define MODE_RUN1 0
`define MODE_RUN2 1
`define MODE_CASCADE 2
`define MODE_HALVE 3

// =====================================================================
// timer_output_control fields
`define OUTCTL_EN1 0
`define OUTCTL_EN2 1

// =====================================================================
// count_clock_select nibble codes
`define SEL_EVT_FALL 4'h0
`define SEL_EVT_RISE 4'h1
`define SEL_DIV_FIRST 4'h6
`define SEL_DIV_LAST 4'hE
`define SEL_DIV_MAX 4'hF
`define SEL_EXP_OFFSET 4'h5
`define SEL_EXP_MAX 4'hB

// =====================================================================
// reset values
`define CLKSEL_RST 8'h00
`define MODE_RST 8'h00
`define OUTCTL_RST 8'h00
`define COUNT_RST 8'h00

`endif

// >>> shared/timer_pair_pkg.sv
package timer_pair_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
    typedef logic [11:0] pre_t;

    typedef enum logic [2:0] {
        SRC_OFF = 3'b001,
        SRC_EVENT = 3'b010,
        SRC_PRESCALE = 3'b100
    } clk_src_e;

endpackage : timer_pair_pkg

// >>> src/compare_store.sv
`timescale 1ns/1ps

module compare_store
    import timer_pair_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // byte write port
    input wire logic wr_en,
    input wire logic wr_sel,
    input wire byte_t wr_data,
    // stored values
    output byte_t value_ch1,
    output byte_t value_ch2
);

    typedef struct packed {
        byte_t v1;
        byte_t v2;
    } store_s;

    store_s s;
    store_s next_s;

    // =================================================================
    // storage, full byte range, no reset
    always_comb begin
        next_s = s;
        if (wr_en && !wr_sel) begin
            next_s.v1 = wr_data;
        end
        if (wr_en && wr_sel) begin
            next_s.v2 = wr_data;
        end
    end

    // contents stay undefined until written
    always_ff @(posedge sys_clk) begin
        s <= next_s;
    end

    assign value_ch1 = s.v1;
    assign value_ch2 = s.v2;

    a_store_write: assert property (
        @(posedge sys_clk) (wr_en && !wr_sel)
            |=> (value_ch1 == $past(wr_data))
    ) else $error("compare byte not stored");

endmodule : compare_store

// >>> src/timer_pair.sv
`timescale 1ns/1ps
`include "timer_pair_defs.svh"

module timer_pair
    import timer_pair_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register access port
    input wire logic [3:0] acc_addr,
    input wire word_t acc_wdata,
    input wire logic acc_write,
    input wire logic acc_read,
    input wire logic acc_word,
    output word_t rd_data,
    output logic rd_valid,
    // external event inputs
    input wire logic event_in_ch1,
    input wire logic event_in_ch2,
    // interrupts and timer outputs
    output logic match_irq_ch1,
    output logic match_irq_ch2,
    output logic timer_out_ch1,
    output logic timer_out_ch2
);

    typedef struct packed {
        byte_t clk_sel;
        byte_t mode;
        byte_t out_ctl;
        pre_t pre;
        logic ev1_prev;
        logic ev2_prev;
        logic tick1;
        logic tick2;
        byte_t cnt1;
        byte_t cnt2;
        logic irq1;
        logic irq2;
        logic out1;
        logic out2;
        word_t rd;
        logic rd_ok;
    } timer_s;

    timer_s s;
    timer_s next_s;
    logic rst_meta;
    logic rst_sync;
    byte_t cmp1;
    byte_t cmp2;
    logic cmp_wr;
    logic cascade;
    logic run1;
    logic run2;
    word_t pair;
    word_t pair_cmp;
    word_t step1;
    word_t step2;
    word_t step16;

    // =================================================================
    // reset release
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // =================================================================
    // helpers
    function automatic clk_src_e src_of(input logic [3:0] sel);
        if (sel == `SEL_EVT_FALL || sel == `SEL_EVT_RISE) begin
            return SRC_EVENT;
        end
        if (sel >= `SEL_DIV_FIRST) begin
            return SRC_PRESCALE;
        end
        return SRC_OFF;
    endfunction : src_of

    // one count clock from prescaler or input edge
    function automatic logic tick_of(input logic [3:0] sel,
                                     input pre_t pre, input logic ev,
                                     input logic ev_prev,
                                     input logic halve);
        logic [3:0] e;
        pre_t mask;
        e = (sel == `SEL_DIV_MAX) ? `SEL_EXP_MAX : sel - `SEL_EXP_OFFSET;
        e = halve ? e : e + 4'h1;
        mask = ~(12'hFFF << e);
        case (src_of(sel))
            SRC_EVENT: begin
                if (sel == `SEL_EVT_RISE) begin
                    return ev && !ev_prev;
                end
                return !ev && ev_prev;
            end
            SRC_PRESCALE: return (pre & mask) == mask;
            default: return 1'b0;
        endcase
    endfunction : tick_of

    // clear on equality, else advance and wrap
    function automatic word_t step(input word_t cnt, input word_t cmp);
        return (cnt == cmp) ? 16'h0000 : cnt + 16'h0001;
    endfunction : step

    // =================================================================
    // compare registers
    assign cmp_wr = acc_write && !acc_word
        && (acc_addr == `ADDR_CMP1 || acc_addr == `ADDR_CMP2);

    compare_store u_cmp (
        .sys_clk(sys_clk),
        .wr_en(cmp_wr),
        .wr_sel(acc_addr == `ADDR_CMP2),
        .wr_data(acc_wdata[7:0]),
        .value_ch1(cmp1),
        .value_ch2(cmp2)
    );

    assign cascade = s.mode[`MODE_CASCADE];
    assign run1 = s.mode[`MODE_RUN1];
    assign run2 = s.mode[`MODE_RUN2];
    assign pair = {s.cnt2, s.cnt1};
    assign pair_cmp = {cmp2, cmp1};
    assign step1 = step({8'h00, s.cnt1}, {8'h00, cmp1});
    assign step2 = step({8'h00, s.cnt2}, {8'h00, cmp2});
    assign step16 = step(pair, pair_cmp);

    // =================================================================
    // counting, outputs and register access
    always_comb begin
        next_s = s;
        next_s.pre = s.pre + 12'h001;
        next_s.ev1_prev = event_in_ch1;
        next_s.ev2_prev = event_in_ch2;
        next_s.tick1 = tick_of(s.clk_sel[3:0], s.pre, event_in_ch1,
                               s.ev1_prev, s.mode[`MODE_HALVE]);
        next_s.tick2 = tick_of(s.clk_sel[7:4], s.pre, event_in_ch2,
                               s.ev2_prev, s.mode[`MODE_HALVE]);
        next_s.irq1 = 1'b0;
        next_s.irq2 = 1'b0;
        next_s.rd_ok = 1'b0;
        if (cascade) begin
            // stopped counters read zero, so a start restarts
            if (!(run1 && run2)) begin
                next_s.cnt1 = `COUNT_RST;
                next_s.cnt2 = `COUNT_RST;
            end else if (s.tick1) begin
                next_s.cnt1 = step16[7:0];
                next_s.cnt2 = step16[15:8];
                next_s.irq1 = (step16 == pair_cmp);
            end
        end else begin
            if (!run1) begin
                next_s.cnt1 = `COUNT_RST;
            end else if (s.tick1) begin
                next_s.cnt1 = step1[7:0];
                next_s.irq1 = (step1[7:0] == cmp1);
            end
            if (!run2) begin
                next_s.cnt2 = `COUNT_RST;
            end else if (s.tick2) begin
                next_s.cnt2 = step2[7:0];
                next_s.irq2 = (step2[7:0] == cmp2);
            end
        end
        next_s.out1 = s.out_ctl[`OUTCTL_EN1] && (s.out1 ^ next_s.irq1);
        next_s.out2 = s.out_ctl[`OUTCTL_EN2] && (s.out2 ^ next_s.irq2);
        // control writes are byte wide only
        if (acc_write && !acc_word) begin
            case (acc_addr)
                `ADDR_CLKSEL: next_s.clk_sel = acc_wdata[7:0];
                `ADDR_MODE: next_s.mode = acc_wdata[7:0];
                `ADDR_OUTCTL: next_s.out_ctl = acc_wdata[7:0];
                default: next_s.mode = s.mode;
            endcase
        end
        if (acc_read) begin
            next_s.rd_ok = 1'b1;
            case (acc_addr)
                `ADDR_CMP1: next_s.rd = {8'h00, cmp1};
                `ADDR_CMP2: next_s.rd = {8'h00, cmp2};
                `ADDR_CNT1: next_s.rd = acc_word ? pair
                                                 : {8'h00, s.cnt1};
                `ADDR_CNT2: next_s.rd = {8'h00, s.cnt2};
                `ADDR_CLKSEL: next_s.rd = {8'h00, s.clk_sel};
                `ADDR_MODE: next_s.rd = {8'h00, s.mode};
                `ADDR_OUTCTL: next_s.rd = {8'h00, s.out_ctl};
                default: next_s.rd = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data = s.rd;
    assign rd_valid = s.rd_ok;
    assign match_irq_ch1 = s.irq1;
    assign match_irq_ch2 = s.irq2;
    assign timer_out_ch1 = s.out1;
    assign timer_out_ch2 = s.out2;

    // =================================================================
    // checks
    a_irq_on_match: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (match_irq_ch1 && !cascade) |-> (s.cnt1 == cmp1)
    ) else $error("irq without 8-bit match");

    a_word_write_cmp: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (acc_write && acc_word) |=> $stable(cmp1) && $stable(cmp2)
    ) else $error("word write changed a compare");

    a_cascade_match: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (match_irq_ch1 && cascade) |-> (pair == pair_cmp)
    ) else $error("cascaded irq without 16-bit match");

    a_count_wraps: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (!cascade && run1 && s.tick1 && s.cnt1 == 8'hFF
            && cmp1 != 8'hFF) |=> (s.cnt1 == 8'h00)
    ) else $error("counter did not wrap");

    a_byte_read: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (acc_read && !acc_word && acc_addr == `ADDR_CNT2)
            |=> rd_valid && rd_data == {8'h00, $past(s.cnt2)}
    ) else $error("byte count read wrong");

    a_word_read: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (acc_read && acc_word && acc_addr == `ADDR_CNT1)
            |=> rd_valid && rd_data == $past(pair)
    ) else $error("word count read wrong");

    a_reset_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_sync) |-> (s.cnt1 == 8'h00 && s.cnt2 == 8'h00)
    ) else $error("counters not clear after reset");

    a_fast_prescale: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (s.tick1 && !acc_write && s.mode[`MODE_HALVE]
            && s.clk_sel[3:0] == `SEL_DIV_FIRST) |=> !s.tick1 ##1 s.tick1
    ) else $error("halved count clock not every two");

    a_event_rise: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (s.clk_sel[7:4] == `SEL_EVT_RISE && event_in_ch2 && !s.ev2_prev)
            |=> s.tick2
    ) else $error("rising event not counted");

    a_cascade_carry: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (cascade && run1 && run2 && s.tick1 && s.cnt1 == 8'hFF
            && pair != pair_cmp)
            |=> s.cnt1 == 8'h00 && s.cnt2 == $past(s.cnt2) + 8'h01
    ) else $error("low byte did not carry");

    a_match_clear: assert property (
        @(posedge sys_clk) disable iff (!rst_sync)
        (!cascade && s.tick1 && s.cnt1 == cmp1) |=> (s.cnt1 == 8'h00)
    ) else $error("counter not cleared after match");

endmodule : timer_pair

// >>> tb/event_source.sv
`timescale 1ns/1ps

// =====================================
// external event pins driven off the falling edge
module event_source (
    // clock
    input wire logic sys_clk,
    // event pins
    output logic event_ch1,
    output logic event_ch2
);
    initial begin
        event_ch1 = 1'b0;
        event_ch2 = 1'b0;
    end

    // each level stands two clocks so every edge is sampled both ways
    task automatic pulse(input int ch, input int cnt);
        repeat (cnt) begin
            @(negedge sys_clk);
            if (ch == 1) event_ch1 = 1'b1; else event_ch2 = 1'b1;
            repeat (2) @(negedge sys_clk);
            if (ch == 1) event_ch1 = 1'b0; else event_ch2 = 1'b0;
            repeat (1) @(negedge sys_clk);
        end
    endtask : pulse
endmodule : event_source

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "timer_pair_defs.svh"

module tb_top
    import timer_pair_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] acc_addr = 4'h0;
    word_t acc_wdata = 16'h0000;
    logic acc_write = 1'b0;
    logic acc_read = 1'b0;
    logic acc_word = 1'b0;
    word_t rd_data;
    logic rd_valid;
    logic ev1;
    logic ev2;
    logic irq1;
    logic irq2;
    logic out1;
    logic out2;
    logic o;
    word_t q;
    int n;
    int n_mismatch = 0;
    int comparisons = 0;

    always #12.5 sys_clk = ~sys_clk;

    event_source ev (.sys_clk(sys_clk), .event_ch1(ev1), .event_ch2(ev2));

    timer_pair dut (.sys_clk(sys_clk), .rst_n(rst_n), .acc_addr(acc_addr),
        .acc_wdata(acc_wdata), .acc_write(acc_write), .acc_read(acc_read),
        .acc_word(acc_word), .rd_data(rd_data), .rd_valid(rd_valid),
        .event_in_ch1(ev1), .event_in_ch2(ev2), .match_irq_ch1(irq1),
        .match_irq_ch2(irq2), .timer_out_ch1(out1), .timer_out_ch2(out2));

    // =====================================
    // access tasks
    task automatic finish_test;
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input word_t got, input word_t exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] a, input word_t d, input logic w);
        @(negedge sys_clk);
        acc_addr = a;
        acc_wdata = d;
        acc_word = w;
        acc_write = 1'b1;
        @(negedge sys_clk);
        acc_write = 1'b0;
    endtask : wr

    // rd_valid stands only in the cycle after the taking edge
    task automatic rd(input logic [3:0] a, input logic w, output word_t d);
        @(negedge sys_clk);
        acc_addr = a;
        acc_word = w;
        acc_read = 1'b1;
        @(negedge sys_clk);
        acc_read = 1'b0;
        check({15'h0000, rd_valid}, 16'h0001);
        d = rd_data;
    endtask : rd

    task automatic wait_irq(input int ch, input int lim, output int cyc);
        cyc = 0;
        do begin
            @(negedge sys_clk);
            cyc++;
        end while (((ch == 1) ? irq1 : irq2) !== 1'b1 && cyc < lim);
        if (cyc >= lim) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_irq

    // =====================================
    // test sequence
    initial begin
        repeat (10) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd(`ADDR_CNT1, 1'b0, q);
        check(q, 16'h0000);
        rd(`ADDR_CNT2, 1'b0, q);
        check(q, 16'h0000);
        rd(`ADDR_CNT1, 1'b1, q);
        check(q, 16'h0000);
        wr(`ADDR_CMP1, 16'h0002, 1'b0);
        wr(`ADDR_CMP2, 16'h00FF, 1'b0);
        wr(`ADDR_CMP1, 16'h0055, 1'b1);
        rd(`ADDR_CMP1, 1'b0, q);
        check(q, 16'h0002);
        rd(`ADDR_CMP2, 1'b0, q);
        check(q, 16'h00FF);
        rd(4'h7, 1'b0, q);
        check(q, 16'h0000);
        // interval timing with both clock scalings
        wr(`ADDR_CLKSEL, 16'h0016, 1'b0);
        wr(`ADDR_OUTCTL, 16'h0003, 1'b0);
        wr(`ADDR_MODE, 16'h0009, 1'b0);
        wait_irq(1, 100, n);
        o = out1;
        wait_irq(1, 100, n);
        check(word_t'(n), 16'h0006);
        check({15'h0000, out1}, {15'h0000, ~o});
        wr(`ADDR_MODE, 16'h0000, 1'b0);
        wr(`ADDR_MODE, 16'h0001, 1'b0);
        wait_irq(1, 100, n);
        wait_irq(1, 100, n);
        check(word_t'(n), 16'h000C);
        // lowering the compare below the count wraps through FFH
        wr(`ADDR_MODE, 16'h0000, 1'b0);
        wr(`ADDR_CMP1, 16'h0010, 1'b0);
        wr(`ADDR_MODE, 16'h0009, 1'b0);
        wait_irq(1, 100, n);
        repeat (16) @(negedge sys_clk);
        wr(`ADDR_CMP1, 16'h0002, 1'b0);
        wait_irq(1, 1000, n);
        check(word_t'(n > 400), 16'h0001);
        wr(`ADDR_MODE, 16'h0000, 1'b0);
        wr(`ADDR_MODE, 16'h0009, 1'b0);
        wait_irq(1, 100, n);
        wait_irq(1, 100, n);
        check(word_t'(n), 16'h0006);
        // event counting on channel 2
        wr(`ADDR_MODE, 16'h0000, 1'b0);
        wr(`ADDR_CMP2, 16'h0003, 1'b0);
        wr(`ADDR_MODE, 16'h000A, 1'b0);
        ev.pulse(2, 2);
        rd(`ADDR_CNT2, 1'b0, q);
        check(q, 16'h0002);
        fork
            ev.pulse(2, 1);
            wait_irq(2, 40, n);
        join
        ev.pulse(2, 1);
        rd(`ADDR_CNT2, 1'b0, q);
        check(q, 16'h0000);
        check({15'h0000, out2}, 16'h0001);
        // falling edges on channel 1
        wr(`ADDR_CLKSEL, 16'h0010, 1'b0);
        wr(`ADDR_MODE, 16'h0009, 1'b0);
        ev.pulse(1, 2);
        rd(`ADDR_CNT1, 1'b0, q);
        check(q, 16'h0002);
        wr(`ADDR_CLKSEL, 16'h0016, 1'b0);
        // cascaded 16-bit period
        wr(`ADDR_MODE, 16'h0000, 1'b0);
        wr(`ADDR_CMP1, 16'h0001, 1'b0);
        wr(`ADDR_CMP2, 16'h0001, 1'b0);
        wr(`ADDR_MODE, 16'h000F, 1'b0);
        wait_irq(1, 1200, n);
        wait_irq(1, 1200, n);
        check(word_t'(n), 16'h0204);
        rd(`ADDR_CNT1, 1'b1, q);
        check(q, 16'h0101);
        // reset in mid-run returns the block to idle
        @(negedge sys_clk);
        rst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd(`ADDR_CNT1, 1'b1, q);
        check(q, 16'h0000);
        rd(`ADDR_MODE, 1'b0, q);
        check(q, 16'h0000);
        finish_test();
    end
endmodule : tb_top
